// ### rtl/amb_pkg.sv
/*
  alert mask bank package: command codes, sub-codes, writable bit
  layouts and the carrier struct for the four status categories.
  assumes nothing of its surroundings.
*/
package amb_pkg;

  localparam logic [7:0] AMB_CMD_ALERT_MASK = 8'h1b;
  localparam logic [7:0] AMB_PHASE_ALL      = 8'hff;

  localparam int AMB_NCAT = 4;
  localparam int AMB_IDX_VOUT = 0;
  localparam int AMB_IDX_IOUT = 1;
  localparam int AMB_IDX_INP  = 2;
  localparam int AMB_IDX_TEMP = 3;

  // sub-codes that pick a category (register offsets)
  localparam logic [7:0] AMB_SUB_VOUT = 8'h7a;
  localparam logic [7:0] AMB_SUB_IOUT = 8'h7b;
  localparam logic [7:0] AMB_SUB_INP  = 8'h7c;
  localparam logic [7:0] AMB_SUB_TEMP = 8'h7d;

  // field positions, output-voltage category
  localparam int AMB_B_OUT_OVERVOLT_FAULT  = 7;
  localparam int AMB_B_OUT_OVERVOLT_WARN   = 6;
  localparam int AMB_B_OUT_UNDERVOLT_WARN  = 5;
  localparam int AMB_B_OUT_UNDERVOLT_FAULT = 4;
  localparam int AMB_B_OUT_LIMIT_RANGE     = 3;
  localparam int AMB_B_TURN_ON_TIMEOUT     = 2;
  // output-current category
  localparam int AMB_B_OVERCURRENT_FAULT   = 7;
  localparam int AMB_B_OVERCURRENT_WARN    = 5;
  localparam int AMB_B_UNDERCURRENT_FAULT  = 4;
  // input category
  localparam int AMB_B_INPUT_LOW           = 3;
  // temperature category
  localparam int AMB_B_OVERTEMP_FAULT      = 7;
  localparam int AMB_B_OVERTEMP_WARN       = 6;

  // writable bits of each mask, indexed by category
  localparam logic [7:0] AMB_WR_VOUT = 8'hfc;
  localparam logic [7:0] AMB_WR_IOUT = 8'hb0;
  localparam logic [7:0] AMB_WR_INP  = 8'h08;
  localparam logic [7:0] AMB_WR_TEMP = 8'hc0;
  localparam logic [AMB_NCAT-1:0][7:0] AMB_WR_MASKS =
    {AMB_WR_TEMP, AMB_WR_INP, AMB_WR_IOUT, AMB_WR_VOUT};

  // value of every mask before the nonvolatile load lands
  localparam logic [7:0] AMB_MASK_RST = 8'h00;

  // one byte per category; index 0 is the lowest byte
  typedef struct packed {
    logic [7:0] temp;
    logic [7:0] inp;
    logic [7:0] iout;
    logic [7:0] vout;
  } amb_cat_t;

endpackage

// ### rtl/amb_mask_reg.sv
/*
  one category mask: loads from nonvolatile storage, takes host writes,
  and only ever holds its writable bits.
  assumes load and write are one-cycle pulses from the owning bank.
*/
`timescale 1ns/1ps
module amb_mask_reg #(
  parameter logic [7:0] WR_MASK = 8'hff
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       load,
  input  wire logic [7:0] load_val,
  input  wire logic       wr,
  input  wire logic [7:0] wr_val,
  output logic      [7:0] mask_q
);

  // read-only bits are cut here so no path can ever read them as set
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mask_q <= amb_pkg::AMB_MASK_RST;
    end else if (wr) begin
      mask_q <= wr_val & WR_MASK;
    end else if (load) begin
      mask_q <= load_val & WR_MASK;
    end
  end

endmodule

// ### rtl/amb_bank.sv
/*
  alert mask bank: four category masks behind the alert mask command,
  written by word write, read by one-byte process call, gating the
  status conditions onto the alert request.
  assumes an upstream bus engine that decodes transactions into the
  one-cycle request pulses below, and a status block that owns the
  status bits and samples them unmasked.
*/
`timescale 1ns/1ps
module amb_bank (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [7:0]       phase,
  input  wire logic             wr_req,
  input  wire logic [7:0]       wr_cmd,
  input  wire logic [7:0]       wr_lo,
  input  wire logic [7:0]       wr_hi,
  input  wire logic             rd_req,
  input  wire logic [7:0]       rd_cmd,
  input  wire logic [7:0]       rd_sub,
  input  wire logic             nvm_load,
  input  wire amb_pkg::amb_cat_t nvm_masks,
  input  wire amb_pkg::amb_cat_t status,
  output logic                  wr_done,
  output logic                  wr_nack,
  output logic                  rd_ack,
  output logic                  rd_nack,
  output logic      [7:0]       rd_data,
  output amb_pkg::amb_cat_t     mask_view,
  output amb_pkg::amb_cat_t     alert_src,
  output logic                  alert_req
);

  typedef enum logic [2:0] {
    AMB_LD_WAIT = 3'b001,
    AMB_LD_GO   = 3'b010,
    AMB_LD_DONE = 3'b100
  } amb_ld_t;

  // sub-code decode, shared by the write and the read path
  function automatic logic [2:0] amb_sub_idx(input logic [7:0] sub);
    logic [2:0] r;
    r = 3'b000;
    unique case (sub)
      amb_pkg::AMB_SUB_VOUT: r = 3'b100;
      amb_pkg::AMB_SUB_IOUT: r = 3'b101;
      amb_pkg::AMB_SUB_INP:  r = 3'b110;
      amb_pkg::AMB_SUB_TEMP: r = 3'b111;
      default:               r = 3'b000;
    endcase
    return r;
  endfunction

  amb_ld_t                    ld_q;
  logic                       ld_pulse;
  logic [2:0]                 wr_sel;
  logic [2:0]                 rd_sel;
  logic                       phase_ok;
  logic                       wr_hit;
  logic                       rd_hit;
  logic [amb_pkg::AMB_NCAT-1:0][7:0] masks;
  logic [amb_pkg::AMB_NCAT-1:0][7:0] nvm_vec;
  logic [amb_pkg::AMB_NCAT-1:0][7:0] stat_vec;
  logic [amb_pkg::AMB_NCAT-1:0][7:0] src_vec;
  logic [7:0]                 vout_alert_mask;
  logic [7:0]                 iout_alert_mask;
  logic [7:0]                 input_alert_mask;
  logic [7:0]                 temperature_alert_mask;
  logic                       mask_out_overvolt_fault;
  logic                       mask_out_overvolt_warn;
  logic                       mask_out_undervolt_warn;
  logic                       mask_out_undervolt_fault;
  logic                       mask_out_limit_range;
  logic                       mask_turn_on_timeout;
  logic                       mask_overcurrent_fault;
  logic                       mask_overcurrent_warn;
  logic                       mask_undercurrent_fault;
  logic                       mask_input_low;
  logic                       mask_overtemp_fault;
  logic                       mask_overtemp_warn;
  logic [7:0]                 vout_fields;
  logic [7:0]                 iout_fields;
  logic [7:0]                 input_fields;
  logic [7:0]                 temp_fields;
  logic [amb_pkg::AMB_NCAT-1:0][7:0] fld_vec;

  assign nvm_vec  = nvm_masks;
  assign stat_vec = status;
  assign phase_ok = (phase == amb_pkg::AMB_PHASE_ALL);
  assign wr_sel   = amb_sub_idx(wr_lo);
  assign rd_sel   = amb_sub_idx(rd_sub);
  assign wr_hit   = wr_req && (wr_cmd == amb_pkg::AMB_CMD_ALERT_MASK) &&
                    phase_ok && wr_sel[2];
  assign rd_hit   = rd_req && (rd_cmd == amb_pkg::AMB_CMD_ALERT_MASK) &&
                    phase_ok && rd_sel[2];

  // the storage is caught on the second edge after release, never under reset,
  // so the asynchronous reset only ever loads a constant
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ld_q <= AMB_LD_WAIT;
    end else begin
      unique case (ld_q)
        AMB_LD_WAIT: ld_q <= AMB_LD_GO;
        AMB_LD_GO:   ld_q <= AMB_LD_DONE;
        AMB_LD_DONE: ld_q <= AMB_LD_DONE;
        default:     ld_q <= AMB_LD_WAIT;
      endcase
    end
  end

  // a later restore from storage reuses the same load path
  assign ld_pulse = (ld_q == AMB_LD_GO) || nvm_load;

  genvar gi;
  generate
    for (gi = 0; gi < amb_pkg::AMB_NCAT; gi++) begin : g_cat
      amb_mask_reg #(
        .WR_MASK (amb_pkg::AMB_WR_MASKS[gi])
      ) u_mask (
        .clk      (clk),
        .nrst     (nrst),
        .load     (ld_pulse),
        .load_val (nvm_vec[gi]),
        .wr       (wr_hit && (wr_sel[1:0] == 2'(gi))),
        .wr_val   (wr_hi),
        .mask_q   (masks[gi])
      );
      // status passes in unchanged; the mask only drops its vote
      assign src_vec[gi] = stat_vec[gi] & ~fld_vec[gi];
    end
  endgenerate

  // register bytes as the host names them
  assign vout_alert_mask        = masks[amb_pkg::AMB_IDX_VOUT];
  assign iout_alert_mask        = masks[amb_pkg::AMB_IDX_IOUT];
  assign input_alert_mask       = masks[amb_pkg::AMB_IDX_INP];
  assign temperature_alert_mask = masks[amb_pkg::AMB_IDX_TEMP];

  // one name per writable field
  assign mask_out_overvolt_fault =
    vout_alert_mask[amb_pkg::AMB_B_OUT_OVERVOLT_FAULT];
  assign mask_out_overvolt_warn =
    vout_alert_mask[amb_pkg::AMB_B_OUT_OVERVOLT_WARN];
  assign mask_out_undervolt_warn =
    vout_alert_mask[amb_pkg::AMB_B_OUT_UNDERVOLT_WARN];
  assign mask_out_undervolt_fault =
    vout_alert_mask[amb_pkg::AMB_B_OUT_UNDERVOLT_FAULT];
  assign mask_out_limit_range =
    vout_alert_mask[amb_pkg::AMB_B_OUT_LIMIT_RANGE];
  assign mask_turn_on_timeout =
    vout_alert_mask[amb_pkg::AMB_B_TURN_ON_TIMEOUT];
  assign mask_overcurrent_fault =
    iout_alert_mask[amb_pkg::AMB_B_OVERCURRENT_FAULT];
  assign mask_overcurrent_warn =
    iout_alert_mask[amb_pkg::AMB_B_OVERCURRENT_WARN];
  assign mask_undercurrent_fault =
    iout_alert_mask[amb_pkg::AMB_B_UNDERCURRENT_FAULT];
  assign mask_input_low =
    input_alert_mask[amb_pkg::AMB_B_INPUT_LOW];
  assign mask_overtemp_fault =
    temperature_alert_mask[amb_pkg::AMB_B_OVERTEMP_FAULT];
  assign mask_overtemp_warn =
    temperature_alert_mask[amb_pkg::AMB_B_OVERTEMP_WARN];

  // the read path and the alert gate see only these rebuilt bytes, so
  // an unsupported position reads zero even if the storage were widened
  always_comb begin
    vout_fields  = 8'h00;
    iout_fields  = 8'h00;
    input_fields = 8'h00;
    temp_fields  = 8'h00;
    vout_fields[amb_pkg::AMB_B_OUT_OVERVOLT_FAULT] = mask_out_overvolt_fault;
    vout_fields[amb_pkg::AMB_B_OUT_OVERVOLT_WARN] = mask_out_overvolt_warn;
    vout_fields[amb_pkg::AMB_B_OUT_UNDERVOLT_WARN] = mask_out_undervolt_warn;
    vout_fields[amb_pkg::AMB_B_OUT_UNDERVOLT_FAULT] = mask_out_undervolt_fault;
    vout_fields[amb_pkg::AMB_B_OUT_LIMIT_RANGE] = mask_out_limit_range;
    vout_fields[amb_pkg::AMB_B_TURN_ON_TIMEOUT] = mask_turn_on_timeout;
    iout_fields[amb_pkg::AMB_B_OVERCURRENT_FAULT] = mask_overcurrent_fault;
    iout_fields[amb_pkg::AMB_B_OVERCURRENT_WARN] = mask_overcurrent_warn;
    iout_fields[amb_pkg::AMB_B_UNDERCURRENT_FAULT] = mask_undercurrent_fault;
    input_fields[amb_pkg::AMB_B_INPUT_LOW] = mask_input_low;
    temp_fields[amb_pkg::AMB_B_OVERTEMP_FAULT] = mask_overtemp_fault;
    temp_fields[amb_pkg::AMB_B_OVERTEMP_WARN] = mask_overtemp_warn;
  end

  assign fld_vec = {temp_fields, input_fields, iout_fields, vout_fields};

  // write answer: done or refused, one cycle after the request
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_done <= 1'b0;
      wr_nack <= 1'b0;
    end else begin
      wr_done <= wr_hit;
      wr_nack <= wr_req && !wr_hit;
    end
  end

  // read answer; refused reads return zero rather than a stale byte
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_ack  <= 1'b0;
      rd_nack <= 1'b0;
      rd_data <= 8'h00;
    end else begin
      rd_ack  <= rd_hit;
      rd_nack <= rd_req && !rd_hit;
      if (rd_req) begin
        rd_data <= rd_hit ? fld_vec[rd_sel[1:0]] : 8'h00;
      end
    end
  end

  // gating follows the mask registers directly, so a write changes
  // the alert vote on the next edge with no regulation pause
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alert_src <= '0;
      alert_req <= 1'b0;
      mask_view <= '0;
    end else begin
      alert_src <= src_vec;
      alert_req <= |src_vec;
      mask_view <= fld_vec;
    end
  end

endmodule

// ### tb/amb_bank_monitor.sv
/* port checker for the alert mask bank.
   assumes status is held low while nrst is low. */
`timescale 1ns/1ps
module amb_bank_monitor (
  input wire logic              clk,
  input wire logic              nrst,
  input wire logic [7:0]        phase,
  input wire logic              wr_req,
  input wire logic [7:0]        wr_cmd,
  input wire logic [7:0]        wr_lo,
  input wire logic [7:0]        wr_hi,
  input wire logic              rd_req,
  input wire logic [7:0]        rd_cmd,
  input wire logic [7:0]        rd_sub,
  input wire logic              nvm_load,
  input wire amb_pkg::amb_cat_t nvm_masks,
  input wire amb_pkg::amb_cat_t status,
  input wire logic              wr_done,
  input wire logic              wr_nack,
  input wire logic              rd_ack,
  input wire logic              rd_nack,
  input wire logic [7:0]        rd_data,
  input wire amb_pkg::amb_cat_t mask_view,
  input wire amb_pkg::amb_cat_t alert_src,
  input wire logic              alert_req
);
  logic [1:0] idx_q;
  // byte index of the last read sub-code; mask_view lags one cycle too
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) idx_q <= 2'd0;
    else idx_q <= rd_sub[1:0] + 2'd2;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_wr_vout;
    wr_req && wr_cmd == 8'h1b && phase == 8'hff && wr_lo == 8'h7a;
  endsequence
  sequence s_rd_hit;
    rd_req && rd_cmd == 8'h1b && phase == 8'hff
      && rd_sub inside {[8'h7a:8'h7d]};
  endsequence
  wr_refuse_a: assert property (wr_req && phase != 8'hff
    |=> wr_nack && !wr_done) else $error("refused write answered");
  rd_refuse_a: assert property (rd_req && phase != 8'hff
    |=> rd_nack && !rd_ack && rd_data == 8'h00) else $error("bad refusal");
  rd_value_a: assert property (s_rd_hit |=> rd_ack
    && rd_data == 8'(mask_view >> {idx_q, 3'd0})) else $error("read data");
  wr_vout_a: assert property (s_wr_vout |=> wr_done ##1
    mask_view.vout == ($past(wr_hi, 2) & 8'hfc)) else $error("vout mask");
  ro_zero_a: assert property (
    (mask_view & 32'h3ff74f03) == '0) else $error("read-only bit set");
  alert_gate_a: assert property (
    alert_src == ($past(status) & ~mask_view)) else $error("gating");
  alert_or_a: assert property (alert_req == |alert_src)
    else $error("alert line");
  nvm_load_a: assert property (nvm_load && !wr_req |=> ##1
    mask_view == ($past(nvm_masks, 2) & 32'hc008b0fc)) else $error("load");
endmodule
bind amb_bank amb_bank_monitor i_mon (
  .clk       (clk),
  .nrst      (nrst),
  .phase     (phase),
  .wr_req    (wr_req),
  .wr_cmd    (wr_cmd),
  .wr_lo     (wr_lo),
  .wr_hi     (wr_hi),
  .rd_req    (rd_req),
  .rd_cmd    (rd_cmd),
  .rd_sub    (rd_sub),
  .nvm_load  (nvm_load),
  .nvm_masks (nvm_masks),
  .status    (status),
  .wr_done   (wr_done),
  .wr_nack   (wr_nack),
  .rd_ack    (rd_ack),
  .rd_nack   (rd_nack),
  .rd_data   (rd_data),
  .mask_view (mask_view),
  .alert_src (alert_src),
  .alert_req (alert_req)
);

// ### tb/amb_host.sv
/* host model: word write and one-byte process call on the mask command.
   assumes answers come one cycle after the request edge. */
`timescale 1ns/1ps
module amb_host (
  input  wire logic       clk,
  input  wire logic       wr_done,
  input  wire logic       wr_nack,
  input  wire logic       rd_ack,
  input  wire logic       rd_nack,
  input  wire logic [7:0] rd_data,
  output logic      [7:0] phase,
  output logic            wr_req,
  output logic      [7:0] wr_cmd,
  output logic      [7:0] wr_lo,
  output logic      [7:0] wr_hi,
  output logic            rd_req,
  output logic      [7:0] rd_cmd,
  output logic      [7:0] rd_sub
);
  initial begin
    phase = 8'hff;
    {wr_req, rd_req, wr_cmd, rd_cmd, wr_lo, rd_sub, wr_hi} = '0;
  end
  task automatic xfer(input logic rd, input logic [7:0] cmd, sub, hi,
                      output logic [9:0] ans);
    @(posedge clk);
    {wr_req, rd_req} <= {!rd, rd};
    {wr_cmd, rd_cmd} <= {cmd, cmd};
    {wr_lo, rd_sub, wr_hi} <= {sub, sub, hi};
    @(posedge clk);
    {wr_req, rd_req} <= 2'b00;
    // released bytes are scrambled so nothing leans on stale data
    {wr_lo, rd_sub, wr_hi} <= {~sub, ~sub, ~hi};
    #1 ans = rd ? {rd_ack, rd_nack, rd_data} : {wr_done, wr_nack, 8'h00};
  endtask
endmodule

// ### tb/amb_bank_tb.sv
/* self-checking bench for amb_bank driven through the host model.
   assumes the bank answers every request on the next edge. */
`timescale 1ns/1ps
module amb_bank_tb;
  logic              clk, nrst, nvm_load, wr_req, rd_req, alert_req;
  logic              wr_done, wr_nack, rd_ack, rd_nack;
  logic [7:0]        phase, wr_cmd, wr_lo, wr_hi, rd_cmd, rd_sub, rd_data;
  amb_pkg::amb_cat_t nvm_masks, status, mask_view, alert_src;
  logic [9:0]        ans;
  int                mismatches, checked;
  amb_bank i_dut (
    .clk       (clk),
    .nrst      (nrst),
    .phase     (phase),
    .wr_req    (wr_req),
    .wr_cmd    (wr_cmd),
    .wr_lo     (wr_lo),
    .wr_hi     (wr_hi),
    .rd_req    (rd_req),
    .rd_cmd    (rd_cmd),
    .rd_sub    (rd_sub),
    .nvm_load  (nvm_load),
    .nvm_masks (nvm_masks),
    .status    (status),
    .wr_done   (wr_done),
    .wr_nack   (wr_nack),
    .rd_ack    (rd_ack),
    .rd_nack   (rd_nack),
    .rd_data   (rd_data),
    .mask_view (mask_view),
    .alert_src (alert_src),
    .alert_req (alert_req)
  );
  amb_host i_host (
    .clk     (clk),
    .wr_done (wr_done),
    .wr_nack (wr_nack),
    .rd_ack  (rd_ack),
    .rd_nack (rd_nack),
    .rd_data (rd_data),
    .phase   (phase),
    .wr_req  (wr_req),
    .wr_cmd  (wr_cmd),
    .wr_lo   (wr_lo),
    .wr_hi   (wr_hi),
    .rd_req  (rd_req),
    .rd_cmd  (rd_cmd),
    .rd_sub  (rd_sub)
  );
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    if (mismatches == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic t_readall(input amb_pkg::amb_cat_t exp);
    for (int i = 0; i < 4; i++) begin
      i_host.xfer(1'b1, 8'h1b, 8'h7a + 8'(i), 8'h00, ans);
      chk(32'(ans), {22'h0, 2'b10, exp[8*i +: 8]});
    end
  endtask
  task automatic t_fields(input logic [7:0] hi);
    for (int i = 0; i < 4; i++) begin
      i_host.xfer(1'b0, 8'h1b, 8'h7a + 8'(i), hi, ans);
      chk(32'(ans), 32'h200);
    end
    t_readall({4{hi}} & amb_pkg::AMB_WR_MASKS);
  endtask
  task automatic t_gating;
    @(posedge clk);
    status <= 32'hc008b0fc;
    repeat (2) @(posedge clk);
    #1 chk(alert_src, 32'h0);
    chk(32'(alert_req), 32'h0);
    i_host.xfer(1'b0, 8'h1b, 8'h7d, 8'h00, ans);
    @(posedge clk);
    #1 chk(alert_src, 32'hc0000000);
    chk(32'(alert_req), 32'h1);
  endtask
  task automatic t_refuse;
    @(posedge clk);
    i_host.phase <= 8'h7f;
    i_host.xfer(1'b0, 8'h1b, 8'h7a, 8'h00, ans);
    chk(32'(ans), 32'h100);
    i_host.xfer(1'b1, 8'h1b, 8'h7b, 8'h00, ans);
    chk(32'(ans), 32'h100);
    @(posedge clk);
    i_host.phase <= 8'hff;
    i_host.xfer(1'b0, 8'h1c, 8'h7a, 8'h00, ans);
    chk(32'(ans), 32'h100);
    i_host.xfer(1'b0, 8'h1b, 8'h7e, 8'h00, ans);
    chk(32'(ans), 32'h100);
    t_readall(32'h0008b0fc);
  endtask
  task automatic t_nvm;
    @(posedge clk);
    nvm_masks <= '0;
    nvm_load <= 1'b1;
    @(posedge clk);
    nvm_load <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk(alert_src, 32'hc008b0fc);
    t_readall('0);
  endtask
  task automatic t_reset;
    // status low across reset, so the gate has nothing stale to show
    @(posedge clk);
    status <= '0;
    nvm_masks <= 32'h5a5a5a5a;
    nrst <= 1'b0;
    @(posedge clk);
    #1 chk(mask_view, 32'h0);
    chk(32'({rd_data, wr_done, rd_ack, alert_req}), 32'h0);
    @(posedge clk);
    nrst <= 1'b1;
    // this write lands on the load edge and must beat the stored value
    i_host.xfer(1'b0, 8'h1b, 8'h7a, 8'h03, ans);
    chk(32'(ans), 32'h200);
    t_readall((32'h5a5a5a5a & amb_pkg::AMB_WR_MASKS) & 32'hffffff00);
  endtask
  initial begin
    {nrst, nvm_load, status, mismatches, checked} = '0;
    nvm_masks = '1;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    t_readall(amb_pkg::AMB_WR_MASKS);
    t_fields(8'h00);
    t_fields(8'hff);
    t_gating();
    t_refuse();
    t_nvm();
    t_reset();
    give_verdict();
  end
  initial begin
    // all scenarios need about a hundred cycles; this leaves ample margin
    repeat (3000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
endmodule
